// ===== rtl/cadd_defs.svh
/*
 constants of the complex add datapath: opcodes, register word
 addresses, status field positions, reset values and limits.
 assumes it is included by bare name from rtl/.
*/
`ifndef CADD_DEFS_SVH
`define CADD_DEFS_SVH
`define CADD_OP_LOW_LSW   16'hE502
`define CADD_OP_PAR_LSW   16'hE3F8
`define CADD_OP_HIGH_LSW  16'hE52A
`define CADD_PAR_MSW_TOP  4'h0
`define CADD_ADDR_STATUS  4'h0
`define CADD_ADDR_VR0     4'h1
`define CADD_ADDR_VR_LAST 4'h9
`define CADD_NUM_VR       9
`define CADD_SHIFT_MSB    4
`define CADD_SHIFT_LSB    0
`define CADD_ROUND_BIT    8
`define CADD_SAT_BIT      9
`define CADD_REAL_OVF_BIT 16
`define CADD_IMAG_OVF_BIT 17
`define CADD_SHIFT_RST    5'h00
`define CADD_ROUND_RST    1'h0
`define CADD_SAT_RST      1'h0
`define CADD_FLAG_RST     1'h0
`define CADD_WAIT_RST     1'h1
`define CADD_RDATA_RST    32'h00000000
`define CADD_DONE_RST     1'h0
`define CADD_VR_RST       32'h00000000
`define CADD_MAX32        32'h7FFFFFFF
`define CADD_MIN32        32'h80000000
`define CADD_LOW_FIRST    4'h5
`define CADD_LOW_SECOND   4'h3
`define CADD_HIGH_FIRST   4'h7
`define CADD_HIGH_SECOND  4'h5
`endif

// ===== rtl/cadd_pkg.sv
/*
 types of the complex add datapath.
 assumes cadd_defs.svh holds the numeric constants.
*/
package cadd_pkg;
   typedef enum logic [1:0] {
      CADD_OP_NONE,
      CADD_OP_LOW,
      CADD_OP_PAR,
      CADD_OP_HIGH
   } cadd_op_t;
endpackage

// ===== rtl/cadd_datapath.sv
/*
 complex 32+32=32 add datapath with vector registers, status
 register and an avalon-mm slave with waitrequest.
 assumes the cpu pipeline presents one decoded-slot instruction
 per cycle on clk, with the memory word already fetched.
*/
`timescale 1ns/100ps
`default_nettype none
`include "cadd_defs.svh"

module cadd_datapath (
   input  wire logic        clk,
   input  wire logic        nrst,
   input  wire logic        ce,
   input  wire logic        instr_valid,
   input  wire logic [15:0] instr_lsw,
   input  wire logic [15:0] instr_msw,
   input  wire logic [31:0] memory_operand_word,
   input  wire logic [3:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   output logic [31:0]      avs_readdata,
   output logic             avs_waitrequest,
   output logic             instr_done
);

   // ==========================================================
   // declarations
   // ==========================================================
   cadd_pkg::cadd_op_t  op;
   logic [3:0]          first_base;
   logic [3:0]          second_base;
   logic                do_add;
   logic [4:0]          right_shift_amount;
   logic                round_enable;
   logic                saturate_enable;
   logic                real_overflow_flag;
   logic                imag_overflow_flag;
   logic [4:0]          next_shift;
   logic                next_round;
   logic                next_sat;
   logic                next_real_ovf;
   logic                next_imag_ovf;
   logic [31:0]         next_readdata;
   logic                next_waitrequest;
   wire logic [31:0]    vr [0:`CADD_NUM_VR-1];
   wire logic [31:0]    lane_res [0:1];
   wire logic           lane_ovf [0:1];
   wire logic [3:0]     lane_dst [0:1];
   wire logic           is_low;
   wire logic           is_par;
   wire logic           is_high;
   wire logic [3:0]     load_dest_reg;
   wire logic           do_load;
   wire logic           bus_req;
   wire logic           bus_ack;
   wire logic           bus_wr;
   wire logic           wr_status;
   wire logic           rd_vr;
   wire logic [3:0]     rd_index;
   wire logic [31:0]    status_word;
   wire logic [31:0]    rd_mux;
   wire logic           sel_status;
   wire logic           clr_real_ovf;
   wire logic           clr_imag_ovf;

   // ==========================================================
   // instruction decode
   // ==========================================================
   assign is_low = instr_valid
                 && (instr_lsw == `CADD_OP_LOW_LSW);

   assign is_par = instr_valid
                 && (instr_lsw == `CADD_OP_PAR_LSW)
                 && (instr_msw[15:12] == `CADD_PAR_MSW_TOP);

   assign is_high = instr_valid
                  && (instr_lsw == `CADD_OP_HIGH_LSW);

   // destination field sits right after the zero nibble
   assign load_dest_reg = instr_msw[11:8];

   assign op = is_low  ? cadd_pkg::CADD_OP_LOW  :
               is_par  ? cadd_pkg::CADD_OP_PAR  :
               is_high ? cadd_pkg::CADD_OP_HIGH :
                         cadd_pkg::CADD_OP_NONE;

   assign do_load = (op == cadd_pkg::CADD_OP_PAR);

   // ==========================================================
   // operand register group selection
   // ==========================================================
   always_comb begin
      first_base  = `CADD_LOW_FIRST;
      second_base = `CADD_LOW_SECOND;
      do_add      = 1'h0;
      case (op)
         cadd_pkg::CADD_OP_LOW: begin
            first_base  = `CADD_LOW_FIRST;
            second_base = `CADD_LOW_SECOND;
            do_add      = 1'h1;
         end
         cadd_pkg::CADD_OP_PAR: begin
            first_base  = `CADD_LOW_FIRST;
            second_base = `CADD_LOW_SECOND;
            do_add      = 1'h1;
         end
         cadd_pkg::CADD_OP_HIGH: begin
            first_base  = `CADD_HIGH_FIRST;
            second_base = `CADD_HIGH_SECOND;
            do_add      = 1'h1;
         end
         default: begin
            first_base  = `CADD_LOW_FIRST;
            second_base = `CADD_LOW_SECOND;
            do_add      = 1'h0;
         end
      endcase
   end

   // ==========================================================
   // lanes: 0 real, 1 imaginary
   // ==========================================================
   genvar l;
   generate
      for (l = 0; l < 2; l = l + 1) begin : g_lane
         wire logic [3:0]  a_idx;
         wire logic [3:0]  b_idx;
         wire logic [31:0] a;
         wire logic [31:0] b;
         wire logic [31:0] shifted;
         wire logic        rbit;
         wire logic [32:0] sum;
         wire logic        ovf;
         wire logic [31:0] clamp;

         // real part at the base register, imaginary one below
         assign a_idx = first_base - 4'(l);
         assign b_idx = second_base - 4'(l);
         assign a     = vr[a_idx];
         assign b     = vr[b_idx];

         // zero shift passes the operand through
         assign shifted = $signed(b) >>> right_shift_amount;

         // top discarded bit, absent when nothing is shifted out
         assign rbit = round_enable
                     && (right_shift_amount != 5'h00)
                     && b[right_shift_amount - 5'h01];

         assign sum = {a[31], a}
                    + {shifted[31], shifted}
                    + {32'h00000000, rbit};

         // sign of the 33-bit sum disagrees with bit 31
         assign ovf = sum[32] ^ sum[31];

         assign clamp = sum[32] ? `CADD_MIN32 : `CADD_MAX32;

         assign lane_res[l] = (saturate_enable && ovf)
                            ? clamp
                            : sum[31:0];

         assign lane_ovf[l] = do_add && ovf;
         assign lane_dst[l] = a_idx;
      end
   endgenerate

   // ==========================================================
   // avalon-mm slave
   // ==========================================================
   // one wait state: request seen, then waitrequest drops
   assign bus_req = avs_read || avs_write;
   assign bus_ack = bus_req && !avs_waitrequest;
   assign bus_wr  = avs_write && bus_ack;

   assign sel_status = (avs_address == `CADD_ADDR_STATUS);

   assign wr_status = bus_wr
                    && sel_status;

   assign rd_vr = (avs_address >= `CADD_ADDR_VR0)
               && (avs_address <= `CADD_ADDR_VR_LAST);

   assign rd_index = avs_address - `CADD_ADDR_VR0;

   assign status_word = {
      14'h0000,
      imag_overflow_flag,
      real_overflow_flag,
      6'h00,
      saturate_enable,
      round_enable,
      3'h0,
      right_shift_amount
   };

   assign rd_mux = sel_status ? status_word  :
                   rd_vr      ? vr[rd_index] :
                                32'h00000000;

   always_comb begin
      next_waitrequest = 1'h1;
      next_readdata    = avs_readdata;
      if (bus_req && avs_waitrequest) begin
         next_waitrequest = 1'h0;
         next_readdata    = rd_mux;
      end
   end

   // ce low freezes the bus answer as well
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         avs_waitrequest <= `CADD_WAIT_RST;
      end else if (ce) begin
         avs_waitrequest <= next_waitrequest;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         avs_readdata <= `CADD_RDATA_RST;
      end else if (ce) begin
         avs_readdata <= next_readdata;
      end
   end

   // ==========================================================
   // status register
   // ==========================================================
   // software clears a flag by writing a one to it
   assign clr_real_ovf = wr_status && avs_writedata[`CADD_REAL_OVF_BIT];
   assign clr_imag_ovf = wr_status && avs_writedata[`CADD_IMAG_OVF_BIT];

   always_comb begin
      next_shift = right_shift_amount;
      next_round = round_enable;
      next_sat   = saturate_enable;
      if (wr_status) begin
         next_shift = avs_writedata[`CADD_SHIFT_MSB:`CADD_SHIFT_LSB];
         next_round = avs_writedata[`CADD_ROUND_BIT];
         next_sat   = avs_writedata[`CADD_SAT_BIT];
      end
      // a set in the clearing cycle wins
      next_real_ovf = (real_overflow_flag && !clr_real_ovf)
                    || lane_ovf[0];
      next_imag_ovf = (imag_overflow_flag && !clr_imag_ovf)
                    || lane_ovf[1];
   end

   // one short flop group per status field
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         right_shift_amount <= `CADD_SHIFT_RST;
      end else if (ce) begin
         right_shift_amount <= next_shift;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         round_enable <= `CADD_ROUND_RST;
      end else if (ce) begin
         round_enable <= next_round;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         saturate_enable <= `CADD_SAT_RST;
      end else if (ce) begin
         saturate_enable <= next_sat;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         real_overflow_flag <= `CADD_FLAG_RST;
      end else if (ce) begin
         real_overflow_flag <= next_real_ovf;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         imag_overflow_flag <= `CADD_FLAG_RST;
      end else if (ce) begin
         imag_overflow_flag <= next_imag_ovf;
      end
   end

   // ==========================================================
   // vector registers
   // ==========================================================
   genvar r;
   generate
      for (r = 0; r < `CADD_NUM_VR; r = r + 1) begin : g_vr
         wire logic        hit_re;
         wire logic        hit_im;
         wire logic        hit_ld;
         wire logic        hit_bus;
         wire logic [31:0] next_q;
         logic      [31:0] q;

         assign hit_re  = do_add && (lane_dst[0] == 4'(r));
         assign hit_im  = do_add && (lane_dst[1] == 4'(r));
         assign hit_ld  = do_load && (load_dest_reg == 4'(r));
         assign hit_bus = bus_wr
                       && (avs_address == (`CADD_ADDR_VR0 + 4'(r)));

         // sum beats a clashing load, load beats the bus
         assign next_q = hit_re  ? lane_res[0]         :
                         hit_im  ? lane_res[1]         :
                         hit_ld  ? memory_operand_word :
                         hit_bus ? avs_writedata       :
                                   q;

         always_ff @(posedge clk or negedge nrst) begin
            if (!nrst) begin
               q <= `CADD_VR_RST;
            end else if (ce) begin
               q <= next_q;
            end
         end

         assign vr[r] = q;
      end
   endgenerate

   // ==========================================================
   // completion strobe
   // ==========================================================
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         instr_done <= `CADD_DONE_RST;
      end else if (ce) begin
         instr_done <= do_add;
      end
   end

endmodule

`default_nettype wire

// ===== test/cadd_asserts.sv
/*
 port assertions of the complex add datapath.
 assumes a bind from the bench top file.
*/
`timescale 1ns/100ps
`default_nettype none
`include "cadd_defs.svh"
module cadd_asserts (
   input wire logic        clk,
   input wire logic        nrst,
   input wire logic        ce,
   input wire logic        instr_valid,
   input wire logic [15:0] instr_lsw,
   input wire logic [15:0] instr_msw,
   input wire logic [3:0]  avs_address,
   input wire logic        avs_read,
   input wire logic        avs_write,
   input wire logic [31:0] avs_readdata,
   input wire logic        avs_waitrequest,
   input wire logic        instr_done
);
   wire logic go  = instr_valid && ce;
   wire logic par = instr_lsw == `CADD_OP_PAR_LSW && instr_msw[15:12] == 4'h0;
   wire logic dec = instr_lsw == `CADD_OP_LOW_LSW || instr_lsw == `CADD_OP_HIGH_LSW || par;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);
   // ====================
   // bus answer
   a_ack_after_req: assert property ((avs_read || avs_write) && avs_waitrequest && ce |=> !avs_waitrequest)
      else $error("bus request not answered next cycle");
   a_ack_one_cycle: assert property (!avs_waitrequest && ce |=> avs_waitrequest)
      else $error("bus answer longer than one cycle");
   a_ack_needs_req: assert property (!avs_waitrequest |-> $past(avs_read || avs_write))
      else $error("bus answer without request");
   a_unmapped_zero: assert property (!avs_waitrequest && $past(avs_read && avs_address > 4'h9) |-> avs_readdata == 32'h0)
      else $error("unmapped read not zero");
   // ====================
   // instruction decode
   a_plain_done: assert property (go && instr_lsw == `CADD_OP_LOW_LSW |=> instr_done)
      else $error("plain add not completed in one cycle");
   a_upper_done: assert property (go && instr_lsw == `CADD_OP_HIGH_LSW |=> instr_done)
      else $error("upper add not completed in one cycle");
   a_par_done: assert property (go && par |=> instr_done)
      else $error("parallel add not completed in one cycle");
   a_done_cause: assert property (instr_done |-> $past(go && dec))
      else $error("done pulse without decoded add");
endmodule
`default_nettype wire

// ===== test/cadd_host.sv
/*
 host pipeline model: issues instructions one cycle after a go.
 assumes the bench drives go and the op fields on clk.
*/
`timescale 1ns/100ps
`default_nettype none
module cadd_host (
   input  wire logic        clk,
   input  wire logic        go,
   input  wire logic [15:0] op_lsw,
   input  wire logic [15:0] op_msw,
   input  wire logic [31:0] op_mem,
   output var logic         instr_valid,
   output var logic [15:0]  instr_lsw,
   output var logic [15:0]  instr_msw,
   output var logic [31:0]  memory_operand_word
);
   wire logic bad = op_msw[11:8] == 4'h4 || op_msw[11:8] == 4'h5 || op_msw[11:8] == 4'h8;
   initial {instr_valid, instr_lsw, instr_msw, memory_operand_word} = 65'h0;
   always @(posedge clk) begin
      instr_valid <= go;
      instr_lsw <= go ? op_lsw : ~instr_lsw;
      instr_msw <= go ? (bad ? {op_msw[15:12], 4'hF, op_msw[7:0]} : op_msw) : ~instr_msw;
      memory_operand_word <= go ? op_mem : ~memory_operand_word;
   end
endmodule
`default_nettype wire

// ===== test/tb.sv
/*
 self-checking bench of the complex add datapath.
 assumes the host model and checker compile first.
*/
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin err_total++; \
   $display("BAD %s exp %h got %h", nm, e, g); end end
module tb;
   logic        clk = 1'h0, nrst = 1'h0, ce = 1'h1, go = 1'h0;
   logic [15:0] op_lsw = 16'h0, op_msw = 16'h0, instr_lsw, instr_msw;
   logic [31:0] op_mem = 32'h0, avs_writedata = 32'h0, avs_readdata, memory_operand_word, q;
   logic [3:0]  avs_address = 4'h0;
   logic        avs_read = 1'h0, avs_write = 1'h0, avs_waitrequest, instr_done, instr_valid;
   logic [31:0] vr [0:8];
   logic [4:0]  shamt;
   logic        round_on, sat, real_ovf, imag_ovf, cr, ci;
   int          err_total = 0, total_checks = 0, seed = 32'h5d248b45;
   always #12.5 clk = ~clk;
   cadd_host host_u (.clk(clk), .go(go), .op_lsw(op_lsw), .op_msw(op_msw), .op_mem(op_mem),
      .instr_valid(instr_valid), .instr_lsw(instr_lsw), .instr_msw(instr_msw),
      .memory_operand_word(memory_operand_word));
   cadd_datapath dut_u (.clk(clk), .nrst(nrst), .ce(ce), .instr_valid(instr_valid), .instr_lsw(instr_lsw),
      .instr_msw(instr_msw), .memory_operand_word(memory_operand_word), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .instr_done(instr_done));
   // ====================
   // expectation model
   function automatic logic [32:0] addp(input logic [31:0] x, input logic [31:0] y);
      logic [31:0] ys;
      logic [32:0] s;
      ys = $signed(y) >>> shamt;
      if (round_on && shamt != 5'h00) ys = ys + y[shamt - 5'h01];
      s = {x[31], x} + {ys[31], ys};
      if (s[32] != s[31] && sat) return {1'h1, s[32] ? 32'h80000000 : 32'h7FFFFFFF};
      return {s[32] != s[31], s[31:0]};
   endfunction
   task automatic model(input logic [15:0] l, input logic [15:0] m, input logic [31:0] w);
      logic [32:0] re, im;
      int f, s;
      f = l == 16'hE52A ? 7 : 5;
      s = l == 16'hE52A ? 5 : 3;
      if (l == 16'hE502 || l == 16'hE52A || (l == 16'hE3F8 && m[15:12] == 4'h0)) begin
         re = addp(vr[f], vr[s]);
         im = addp(vr[f-1], vr[s-1]);
         if (l == 16'hE3F8 && m[11:8] <= 4'h8) vr[m[11:8]] = w;
         vr[f] = re[31:0];
         vr[f-1] = im[31:0];
         real_ovf |= re[32];
         imag_ovf |= im[32];
      end
   endtask
   // ====================
   // drivers
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
      int n;
      n = 0;
      avs_address <= a;
      avs_write <= wr;
      avs_read <= !wr;
      avs_writedata <= d;
      do begin @(posedge clk); n++; end while (avs_waitrequest !== 1'h0 && n < 50);
      q = avs_readdata;
      avs_read <= 1'h0;
      avs_write <= 1'h0;
      @(posedge clk);
      if (n >= 50) begin err_total++; wrap_up(); end
   endtask
   task automatic issue(input logic [31:0] w, input logic hold);
      logic [15:0] opt [5];
      logic [3:0]  dl [6];
      logic [15:0] m;
      int k, ix;
      opt = '{16'hE502, 16'hE3F8, 16'hE52A, 16'hE5FF, 16'hE3F8};
      dl = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h6, 4'h7};
      ce <= !hold;
      for (k = 0; k < 2; k++) begin
         ix = $unsigned($random(seed)) % 5;
         m = {ix == 4 ? 4'h3 : 4'h0, dl[$unsigned($random(seed)) % 6], 8'hA5};
         op_lsw <= opt[ix];
         op_msw <= m;
         op_mem <= w + k;
         go <= 1'h1;
         if (!hold) model(opt[ix], m, w + k);
         @(posedge clk);
      end
      go <= 1'h0;
      repeat (3) @(posedge clk);
      ce <= 1'h1;
   endtask
   // ====================
   // main sequence
   initial begin
      repeat (12) @(posedge clk);
      nrst <= 1'h1;
      @(posedge clk);
      for (int r = 0; r < 16; r++) begin bus(1'h0, r[3:0], 32'h0); `CHK("reset word", 32'h0, q) end
      bus(1'h1, 4'hC, 32'hFFFFFFFF);
      bus(1'h0, 4'hC, 32'h0);
      `CHK("unmapped", 32'h0, q)
      bus(1'h1, 4'h0, 32'hFFFFFFFF);
      bus(1'h0, 4'h0, 32'h0);
      `CHK("status reserved", 32'h0000031F, q)
      {real_ovf, imag_ovf} = 2'h0;
      foreach (vr[r]) vr[r] = 32'h0;
      for (int i = 0; i < 40; i++) begin
         shamt = i < 2 ? 5'(i * 31) : 5'($random(seed));
         {round_on, sat, cr, ci} = 4'($random(seed));
         bus(1'h1, 4'h0, {14'h0, ci, cr, 6'h0, sat, round_on, 3'h0, shamt});
         real_ovf &= !cr;
         imag_ovf &= !ci;
         for (int r = 2; r <= 7; r++) begin
            vr[r] = i < 4 ? {i[0], {31{~i[0]}}} : 32'($random(seed));
            bus(1'h1, 4'(r + 1), vr[r]);
         end
         // every eighth test holds ce low: nothing may change
         issue(32'($random(seed)), i % 8 == 7);
         for (int r = 0; r <= 8; r++) begin bus(1'h0, 4'(r + 1), 32'h0); `CHK("vec_reg", vr[r], q) end
         bus(1'h0, 4'h0, 32'h0);
         `CHK("vector_status", {14'h0, imag_ovf, real_ovf, 6'h0, sat, round_on, 3'h0, shamt}, q)
         $display("test %0d done", i);
      end
      wrap_up();
   end
endmodule
bind cadd_datapath cadd_asserts chk_u (.clk(clk), .nrst(nrst), .ce(ce), .instr_valid(instr_valid),
   .instr_lsw(instr_lsw), .instr_msw(instr_msw), .avs_address(avs_address), .avs_read(avs_read),
   .avs_write(avs_write), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .instr_done(instr_done));
`default_nettype wire
